// >>> logic/wbm_match.sv
/*
 * watchpoint and breakpoint match logic with the debug abort cause flag.
 * holds the value/mask register pairs of each watchpoint unit, written and
 * read from the test access port update stage, raises a break request or a
 * monitor-mode abort request, and keeps the one-bit abort cause register that
 * the core reaches by coprocessor transfers.
 * assumes all debugger and core inputs are on I_CLK, except the external
 * condition pins, which are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module wbm_match #(
   parameter int N_UNITS = 2, // number of watchpoint units
   parameter int DATA_W = wbm_pkg::DATA_W // bus width
) (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   // debugger register port from the scan update stage
   input wire logic I_DBG_WR,
   input wire logic I_DBG_RD,
   input wire logic [wbm_pkg::RADDR_W-1:0] I_DBG_ADDR,
   input wire logic [DATA_W-1:0] I_DBG_WDATA,
   output logic [DATA_W-1:0] O_DBG_RDATA,
   // debug control bits held elsewhere
   input wire logic I_CMP_DISABLE,
   input wire logic I_MONITOR_MODE,
   // core bus cycle
   input wire logic I_BUS_VALID,
   input wire logic [DATA_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_DATA,
   input wire logic I_WRITE,
   input wire logic [1:0] I_SIZE,
   input wire logic I_ACCESS_KIND_BIT,
   input wire logic I_PRIVILEGE_BIT,
   input wire logic I_HALF_FETCH,
   input wire logic [N_UNITS-1:0] I_EXTERNAL_CONDITION_INPUT,
   // core abort entry
   input wire logic I_ABORT_ENTRY,
   input wire logic I_EXT_ABORT,
   // coprocessor transfers
   input wire logic I_COPROCESSOR_READ_INSTR,
   input wire logic I_COPROCESSOR_WRITE_INSTR,
   input wire logic [DATA_W-1:0] I_CP_WDATA,
   output logic [DATA_W-1:0] O_CP_RDATA,
   // results
   output logic O_MATCH_BREAK_REQUEST,
   output logic O_MATCH_ABORT_REQUEST,
   output logic O_DEBUG_ABORT_FLAG
);
   // ************************************************************
   // external condition synchroniser
   // ************************************************************
   logic [N_UNITS-1:0] ext_meta; // first stage, read only by ext_sync
   logic [N_UNITS-1:0] ext_sync; // safe copy

   // two flops per pin
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ext_meta <= '0;
         ext_sync <= '0;
      end else begin
         ext_meta <= I_EXTERNAL_CONDITION_INPUT;
         ext_sync <= ext_meta;
      end
   end

   // ************************************************************
   // watchpoint units
   // ************************************************************
   logic [DATA_W-1:0] addr_val [N_UNITS]; // address value
   logic [DATA_W-1:0] addr_msk [N_UNITS]; // address mask
   logic [DATA_W-1:0] data_val [N_UNITS]; // data value
   logic [DATA_W-1:0] data_msk [N_UNITS]; // data mask
   logic [wbm_pkg::CTLV_W-1:0] ctl_val [N_UNITS]; // control value + enable
   logic [wbm_pkg::CTL_W-1:0] ctl_msk [N_UNITS]; // control mask
   logic [N_UNITS-1:0] ac_match; // address and control matched
   logic [N_UNITS-1:0] d_match; // data matched
   logic [N_UNITS-1:0] hit; // full match of a unit
   logic [N_UNITS-1:0] chain_q; // chain register of each unit above unit 0, which is tied to 0
   logic [N_UNITS-1:0] unit_sel; // debugger addresses this unit

   genvar n;
   generate
      for (n = 0; n < N_UNITS; n++) begin : g_unit
         localparam logic [1:0] UNIT_CODE = 2'(n + 1); // address[4:3] of unit
         logic chain_in; // chain input from next unit
         logic range_in; // range input from next unit
         logic [wbm_pkg::CTL_W-1:0] ctl_in; // live control vector
         logic wr_here; // register write to this unit

         assign unit_sel[n] = (I_DBG_ADDR[4:3] == UNIT_CODE);
         assign wr_here = I_DBG_WR && unit_sel[n];

         // last unit has no neighbour to chain to
         if (n < N_UNITS - 1) begin : g_link
            assign chain_in = chain_q[n+1];
            assign range_in = hit[n+1];
         end else begin : g_end
            assign chain_in = 1'b0;
            assign range_in = 1'b0;
         end

         // control inputs in the value register bit order
         assign ctl_in = {range_in, chain_in, ext_sync[n], I_PRIVILEGE_BIT,
                          I_ACCESS_KIND_BIT, I_SIZE, I_WRITE};

         // value and mask registers, written from the debugger port
         always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               addr_val[n] <= wbm_pkg::WORD_RESET;
               addr_msk[n] <= wbm_pkg::WORD_RESET;
               data_val[n] <= wbm_pkg::WORD_RESET;
               data_msk[n] <= wbm_pkg::WORD_RESET;
               ctl_val[n] <= wbm_pkg::CTLV_RESET;
               ctl_msk[n] <= wbm_pkg::CTLM_RESET;
            end else if (wr_here) begin
               unique case (I_DBG_ADDR[2:0])
                  wbm_pkg::REG_ADDR_VAL: addr_val[n] <= I_DBG_WDATA;
                  wbm_pkg::REG_ADDR_MSK: addr_msk[n] <= I_DBG_WDATA;
                  wbm_pkg::REG_DATA_VAL: data_val[n] <= I_DBG_WDATA;
                  wbm_pkg::REG_DATA_MSK: data_msk[n] <= I_DBG_WDATA;
                  wbm_pkg::REG_CTL_VAL: ctl_val[n] <= I_DBG_WDATA[wbm_pkg::CTLV_W-1:0];
                  wbm_pkg::REG_CTL_MSK: ctl_msk[n] <= I_DBG_WDATA[wbm_pkg::CTL_W-1:0];
                  default: begin
                     // unused register codes write nothing
                  end
               endcase
            end
         end

         // comparator of this unit
         wbm_unit_cmp #(
            .DATA_W(DATA_W)
         ) u_cmp (
            .i_addr_val(addr_val[n]),
            .i_addr_msk(addr_msk[n]),
            .i_data_val(data_val[n]),
            .i_data_msk(data_msk[n]),
            .i_ctl_val(ctl_val[n][wbm_pkg::CTL_W-1:0]),
            .i_ctl_msk(ctl_msk[n]),
            .i_addr(I_ADDR),
            .i_data(I_DATA),
            .i_half_fetch(I_HALF_FETCH),
            .i_ctl_in(ctl_in),
            .o_addr_ctl_match(ac_match[n]),
            .o_data_match(d_match[n])
         );

         // enable bit is never masked
         assign hit[n] = I_BUS_VALID && ac_match[n] && d_match[n]
                         && ctl_val[n][wbm_pkg::CTL_ENABLE];

         // chain register: loads data compare when address/control match,
         // cleared by a control value write to this unit
         if (n > 0) begin : g_chain
            always_ff @(posedge I_CLK or negedge I_RESET_N) begin
               if (!I_RESET_N) begin
                  chain_q[n] <= 1'b0;
               end else if (wr_here && I_DBG_ADDR[2:0] == wbm_pkg::REG_CTL_VAL) begin
                  chain_q[n] <= 1'b0;
               end else if (I_BUS_VALID && ac_match[n]) begin
                  chain_q[n] <= d_match[n];
               end
            end
         end else begin : g_nochain
            assign chain_q[n] = 1'b0;
         end
      end
   endgenerate

   // ************************************************************
   // debugger read-back
   // ************************************************************
   logic [DATA_W-1:0] next_dbg_rdata; // selected register
   int u; // unit index

   // mux of the addressed register, zero when unmapped
   always_comb begin
      next_dbg_rdata = '0;
      for (u = 0; u < N_UNITS; u++) begin
         if (unit_sel[u]) begin
            unique case (I_DBG_ADDR[2:0])
               wbm_pkg::REG_ADDR_VAL: next_dbg_rdata = addr_val[u];
               wbm_pkg::REG_ADDR_MSK: next_dbg_rdata = addr_msk[u];
               wbm_pkg::REG_DATA_VAL: next_dbg_rdata = data_val[u];
               wbm_pkg::REG_DATA_MSK: next_dbg_rdata = data_msk[u];
               wbm_pkg::REG_CTL_VAL: next_dbg_rdata = DATA_W'(ctl_val[u]);
               wbm_pkg::REG_CTL_MSK: next_dbg_rdata = DATA_W'(ctl_msk[u]);
               default: next_dbg_rdata = '0;
            endcase
         end
      end
   end

   // read data register, holds between reads
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_DBG_RDATA <= '0;
      end else if (I_DBG_RD) begin
         O_DBG_RDATA <= next_dbg_rdata;
      end
   end

   // ************************************************************
   // break and abort requests
   // ************************************************************
   logic any_hit; // some enabled unit matched, comparators live
   logic abort_pending; // monitor-mode match awaiting abort entry

   assign any_hit = (|hit) && !I_CMP_DISABLE;

   // one-cycle request pulses, routed by monitor mode
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_MATCH_BREAK_REQUEST <= 1'b0;
         O_MATCH_ABORT_REQUEST <= 1'b0;
      end else begin
         O_MATCH_BREAK_REQUEST <= any_hit && !I_MONITOR_MODE;
         O_MATCH_ABORT_REQUEST <= any_hit && I_MONITOR_MODE;
      end
   end

   // remembers that the next abort entry is ours; new match wins over clear
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         abort_pending <= 1'b0;
      end else if (any_hit && I_MONITOR_MODE) begin
         abort_pending <= 1'b1;
      end else if (I_ABORT_ENTRY) begin
         abort_pending <= 1'b0;
      end
   end

   // ************************************************************
   // debug abort cause register
   // ************************************************************
   logic flag_set; // abort entry caused by a match

   assign flag_set = I_ABORT_ENTRY && abort_pending && !I_EXT_ABORT;

   // sticky flag; hardware set beats a coprocessor write
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_DEBUG_ABORT_FLAG <= wbm_pkg::FLAG_RESET;
      end else if (flag_set) begin
         O_DEBUG_ABORT_FLAG <= 1'b1;
      end else if (I_COPROCESSOR_WRITE_INSTR) begin
         O_DEBUG_ABORT_FLAG <= I_CP_WDATA[wbm_pkg::ABORT_FLAG_BIT];
      end
   end

   // coprocessor read: flag in bit 0, upper bits zero
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CP_RDATA <= '0;
      end else if (I_COPROCESSOR_READ_INSTR) begin
         O_CP_RDATA <= {{(DATA_W-1){1'b0}}, O_DEBUG_ABORT_FLAG};
      end
   end
endmodule : wbm_match

`default_nettype wire

// >>> logic/wbm_pkg.sv
/*
 * constants shared by the watchpoint match logic: register map of the
 * watchpoint units, control field positions and reset values.
 * assumes a 5-bit register address from the test access port update stage.
 */
`default_nettype none

package wbm_pkg;
   // ************************************************************
   // widths
   // ************************************************************
   localparam int DATA_W = 32; // bus address and data width
   localparam int RADDR_W = 5; // debugger register address width
   localparam int CTL_W = 8; // maskable control bits
   localparam int CTLV_W = 9; // control value bits incl. enable

   // ************************************************************
   // register map: address[4:3] picks unit, address[2:0] picks register
   // ************************************************************
   localparam logic [1:0] UNIT_BASE = 2'h1; // unit n sits at code n+1
   localparam logic [2:0] REG_ADDR_VAL = 3'h0; // address value
   localparam logic [2:0] REG_ADDR_MSK = 3'h1; // address mask
   localparam logic [2:0] REG_DATA_VAL = 3'h2; // data value
   localparam logic [2:0] REG_DATA_MSK = 3'h3; // data mask
   localparam logic [2:0] REG_CTL_VAL = 3'h4; // control value
   localparam logic [2:0] REG_CTL_MSK = 3'h5; // control mask

   // ************************************************************
   // control value / mask field positions
   // ************************************************************
   localparam int CTL_WRITE = 0; // direction
   localparam int CTL_SIZE_LO = 1; // access size, two bits
   localparam int CTL_ACCESS_KIND = 3; // 0 fetch, 1 data
   localparam int CTL_PRIVILEGE = 4; // 0 user, 1 privileged
   localparam int CTL_EXT_COND = 5; // external condition
   localparam int CTL_CHAIN = 6; // chained unit
   localparam int CTL_RANGE = 7; // range coupled unit
   localparam int CTL_ENABLE = 8; // value register only

   // ************************************************************
   // debug abort cause register and reset values
   // ************************************************************
   localparam int ABORT_FLAG_BIT = 0; // only live bit
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000; // address and data value/mask regs
   localparam logic [CTLV_W-1:0] CTLV_RESET = 9'h000; // unit disabled
   localparam logic [CTL_W-1:0] CTLM_RESET = 8'h00; // control mask
   localparam logic FLAG_RESET = 1'b0; // no stale abort cause
endpackage : wbm_pkg

`default_nettype wire

// >>> logic/wbm_unit_cmp.sv
/*
 * one watchpoint comparator: address, data and control compare with
 * ignore-style masks. purely combinational.
 * assumes bus inputs are already in the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module wbm_unit_cmp #(
   parameter int DATA_W = wbm_pkg::DATA_W
) (
   input wire logic [DATA_W-1:0] i_addr_val,
   input wire logic [DATA_W-1:0] i_addr_msk,
   input wire logic [DATA_W-1:0] i_data_val,
   input wire logic [DATA_W-1:0] i_data_msk,
   input wire logic [wbm_pkg::CTL_W-1:0] i_ctl_val,
   input wire logic [wbm_pkg::CTL_W-1:0] i_ctl_msk,
   input wire logic [DATA_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic i_half_fetch,
   input wire logic [wbm_pkg::CTL_W-1:0] i_ctl_in,
   output logic o_addr_ctl_match,
   output logic o_data_match
);
   // ************************************************************
   // compare
   // ************************************************************
   localparam int HALF_W = DATA_W / 2; // compressed instruction width

   logic [DATA_W-1:0] data_care; // data lanes that take part
   logic [DATA_W-1:0] data_hit; // per-bit data comparator

   // a set mask bit forces its comparator to match
   assign o_addr_ctl_match = &((~(i_addr ^ i_addr_val)) | i_addr_msk)
      & (&((~(i_ctl_in ^ i_ctl_val)) | i_ctl_msk));

   // on a compressed fetch only the half picked by address bit 1 counts
   always_comb begin
      data_care = {DATA_W{1'b1}};
      if (i_half_fetch) begin
         data_care = i_addr[1] ? {{HALF_W{1'b1}}, {HALF_W{1'b0}}}
                               : {{HALF_W{1'b0}}, {HALF_W{1'b1}}};
      end
   end

   assign data_hit = (~(i_data ^ i_data_val)) | i_data_msk | ~data_care;
   assign o_data_match = &data_hit;
endmodule : wbm_unit_cmp

`default_nettype wire

// >>> tb/wbm_match_props.sv
/*
 * port checker for the watchpoint match block: request steering and the
 * debug abort cause flag.
 * assumes it is bound to wbm_match, one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module wbm_match_props (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_CMP_DISABLE,
   input wire logic I_MONITOR_MODE,
   input wire logic I_BUS_VALID,
   input wire logic I_ABORT_ENTRY,
   input wire logic I_EXT_ABORT,
   input wire logic I_COPROCESSOR_READ_INSTR,
   input wire logic I_COPROCESSOR_WRITE_INSTR,
   input wire logic [wbm_pkg::DATA_W-1:0] I_CP_WDATA,
   input wire logic [wbm_pkg::DATA_W-1:0] O_CP_RDATA,
   input wire logic O_MATCH_BREAK_REQUEST,
   input wire logic O_MATCH_ABORT_REQUEST,
   input wire logic O_DEBUG_ABORT_FLAG
);
   // ************************************
   // properties
   // ************************************
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   cmp_off_quiet_a: assert property ($past(I_CMP_DISABLE) |->
      !O_MATCH_BREAK_REQUEST && !O_MATCH_ABORT_REQUEST) else $error("request while disabled");
   break_steer_a: assert property (O_MATCH_BREAK_REQUEST |->
      !$past(I_MONITOR_MODE) && $past(I_BUS_VALID)) else $error("break request misplaced");
   abort_steer_a: assert property (O_MATCH_ABORT_REQUEST |->
      $past(I_MONITOR_MODE) && $past(I_BUS_VALID)) else $error("abort request misplaced");
   // abort entry in the cycle after a monitor-mode request, no entry in between
   flag_set_a: assert property (I_ABORT_ENTRY && !I_EXT_ABORT
      && $past(O_MATCH_ABORT_REQUEST) && !$past(I_ABORT_ENTRY)
      |=> O_DEBUG_ABORT_FLAG) else $error("flag not set");
   ext_wins_a: assert property (I_ABORT_ENTRY && I_EXT_ABORT && !O_DEBUG_ABORT_FLAG
      && !I_COPROCESSOR_WRITE_INSTR |=> !O_DEBUG_ABORT_FLAG) else $error("flag set on ext");
   flag_hold_a: assert property (O_DEBUG_ABORT_FLAG && !I_COPROCESSOR_WRITE_INSTR
      |=> O_DEBUG_ABORT_FLAG) else $error("flag dropped");
   flag_clear_a: assert property (I_COPROCESSOR_WRITE_INSTR && !I_CP_WDATA[0]
      && !I_ABORT_ENTRY |=> !O_DEBUG_ABORT_FLAG) else $error("flag not cleared");
   cause_read_a: assert property (I_COPROCESSOR_READ_INSTR |=>
      O_CP_RDATA == {31'h0, $past(O_DEBUG_ABORT_FLAG)}) else $error("cause read wrong");
   // reset seen on two edges, so the flop has surely been cleared
   flag_reset_a: assert property (disable iff (1'b0) !I_RESET_N && !$past(I_RESET_N)
      |-> !O_DEBUG_ABORT_FLAG) else $error("flag set in reset");
   cover property (O_MATCH_BREAK_REQUEST);
   cover property (O_MATCH_ABORT_REQUEST);
   cover property ($rose(O_DEBUG_ABORT_FLAG));
endmodule : wbm_match_props

bind wbm_match wbm_match_props u_props (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
   .I_CMP_DISABLE(I_CMP_DISABLE), .I_MONITOR_MODE(I_MONITOR_MODE),
   .I_BUS_VALID(I_BUS_VALID), .I_ABORT_ENTRY(I_ABORT_ENTRY), .I_EXT_ABORT(I_EXT_ABORT),
   .I_COPROCESSOR_READ_INSTR(I_COPROCESSOR_READ_INSTR),
   .I_COPROCESSOR_WRITE_INSTR(I_COPROCESSOR_WRITE_INSTR), .I_CP_WDATA(I_CP_WDATA),
   .O_CP_RDATA(O_CP_RDATA), .O_MATCH_BREAK_REQUEST(O_MATCH_BREAK_REQUEST),
   .O_MATCH_ABORT_REQUEST(O_MATCH_ABORT_REQUEST), .O_DEBUG_ABORT_FLAG(O_DEBUG_ABORT_FLAG));

`default_nettype wire

// >>> tb/wbm_dbg_host.sv
/*
 * debugger host model: register writes and reads at the scan update port.
 * assumes the bench calls its tasks; all signals move after I_CLK edges.
 */
`timescale 1ns/1ps
`default_nettype none

module wbm_dbg_host (
   input wire logic i_clk,
   input wire logic [31:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [4:0] o_addr,
   output logic [31:0] o_wdata,
   output logic o_cmp_dis
);
   // idle port at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 5'h00;
      o_wdata = 32'h00000000;
      o_cmp_dis = 1'b0;
   end
   // one register write
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d; // released bus shows no stale word
   endtask : wr
   // one register read
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask : rd
   // program all six registers of one unit with comparators off
   task automatic prog(input logic [1:0] u, input logic [31:0] av, am, dv, dm, cv, cm);
      logic [1:0] c;
      c = wbm_pkg::UNIT_BASE + u;
      o_cmp_dis <= 1'b1;
      wr({c, wbm_pkg::REG_ADDR_VAL}, av);
      wr({c, wbm_pkg::REG_ADDR_MSK}, am);
      wr({c, wbm_pkg::REG_DATA_VAL}, dv);
      wr({c, wbm_pkg::REG_DATA_MSK}, dm);
      wr({c, wbm_pkg::REG_CTL_VAL}, cv);
      wr({c, wbm_pkg::REG_CTL_MSK}, cm);
      @(posedge i_clk);
      o_cmp_dis <= 1'b0;
   endtask : prog
endmodule : wbm_dbg_host

`default_nettype wire

// >>> tb/wbm_match_bench.sv
/*
 * self-checking bench for wbm_match: breakpoints, watchpoint, abort flag.
 * assumes wbm_pkg, the host model and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module wbm_match_bench;
   logic clk, rst_n, valid, kind, wr, half, mon, ab_en, ext, cpr, cpw;
   logic [1:0] size, xc; // xc: external condition pins
   logic [31:0] addr, data, cpd, r;
   logic dwr, drd, cdis, brk, abt, flag, priv;
   logic [4:0] dad;
   logic [31:0] dwd, drdata, cprd, saved; // saved: instruction under a patch
   int mismatches, checks, cycles;
   // ************************************
   // design and host
   // ************************************
   wbm_match #(.N_UNITS(2)) u_dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_DBG_WR(dwr),
      .I_DBG_RD(drd), .I_DBG_ADDR(dad), .I_DBG_WDATA(dwd), .O_DBG_RDATA(drdata),
      .I_CMP_DISABLE(cdis), .I_MONITOR_MODE(mon), .I_BUS_VALID(valid), .I_ADDR(addr),
      .I_DATA(data), .I_WRITE(wr), .I_SIZE(size), .I_ACCESS_KIND_BIT(kind),
      .I_PRIVILEGE_BIT(priv), .I_HALF_FETCH(half), .I_EXTERNAL_CONDITION_INPUT(xc),
      .I_ABORT_ENTRY(ab_en), .I_EXT_ABORT(ext), .I_COPROCESSOR_READ_INSTR(cpr),
      .I_COPROCESSOR_WRITE_INSTR(cpw), .I_CP_WDATA(cpd), .O_CP_RDATA(cprd),
      .O_MATCH_BREAK_REQUEST(brk), .O_MATCH_ABORT_REQUEST(abt), .O_DEBUG_ABORT_FLAG(flag));
   wbm_dbg_host u_host (.i_clk(clk), .i_rdata(drdata), .o_wr(dwr), .o_rd(drd),
      .o_addr(dad), .o_wdata(dwd), .o_cmp_dis(cdis));
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ************************************
   // tasks
   // ************************************
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one bus cycle, then the registered request outputs
   task automatic bus(input logic [31:0] a, d, input logic k, w, input logic [1:0] s,
      input logic h, br, ab);
      @(posedge clk);
      valid <= 1'b1;
      addr <= a;
      data <= d;
      kind <= k;
      wr <= w;
      size <= s;
      half <= h;
      @(posedge clk);
      valid <= 1'b0;
      data <= ~d; // idle bus carries no stale data
      #1;
      chk("break request", {31'h0, br}, {31'h0, brk});
      chk("abort request", {31'h0, ab}, {31'h0, abt});
   endtask : bus
   // coprocessor write (w=1) or read (w=0)
   task automatic cp(input logic w, input logic d);
      @(posedge clk);
      if (w) cpw <= 1'b1;
      else cpr <= 1'b1;
      cpd <= {31'h0, d};
      @(posedge clk);
      cpw <= 1'b0;
      cpr <= 1'b0;
      #1;
   endtask : cp
   // abort entry, external abort or not
   task automatic abort_in(input logic x);
      @(posedge clk);
      ab_en <= 1'b1;
      ext <= x;
      @(posedge clk);
      ab_en <= 1'b0;
      #1;
   endtask : abort_in
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ************************************
   // tests
   // ************************************
   initial begin
      {rst_n, valid, kind, wr, half, mon, ab_en, ext, cpr, cpw} = 10'h000;
      size = 2'h0;
      addr = 32'h00000000;
      data = 32'h00000000;
      cpd = 32'h00000000;
      priv = 1'b1;
      xc = 2'h0;
      saved = 32'h00000000;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("flag", 32'h00000000, {31'h0, flag});
      cp(1'b0, 1'b0);
      chk("cause", 32'h00000000, cprd);
      $display("test reset done");
      u_host.wr(5'h0C, 32'hFFFFFFFF);
      u_host.rd(5'h0C, r);
      chk("ctl value", 32'h000001FF, r);
      u_host.wr(5'h04, 32'hFFFFFFFF);
      u_host.rd(5'h04, r);
      chk("unmapped", 32'h00000000, r);
      $display("test registers done");
      u_host.prog(2'h0, 32'h100, 32'h3, 32'h0, 32'hFFFFFFFF, 32'h100, 32'hF7);
      bus(32'h102, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
      bus(32'h104, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      bus(32'h100, 32'h1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      u_host.o_cmp_dis <= 1'b1;
      bus(32'h100, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      u_host.o_cmp_dis <= 1'b0;
      u_host.prog(2'h0, 32'h100, 32'h1, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hF7);
      bus(32'h100, 32'h1, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0);
      // range of 16 addresses, user fetch, external condition required
      priv <= 1'b0;
      xc <= 2'h1;
      u_host.prog(2'h0, 32'h200, 32'hF, 32'h0, 32'hFFFFFFFF, 32'h120, 32'hC7);
      bus(32'h20C, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
      bus(32'h210, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      priv <= 1'b1;
      bus(32'h20C, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      priv <= 1'b0;
      xc <= 2'h0;
      // let the pin through its two synchroniser flops
      repeat (2) @(posedge clk);
      bus(32'h20C, 32'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      $display("test hardware breakpoint done");
      u_host.prog(2'h1, 32'h0, 32'hFFFFFFFF, 32'hDFFFDFFF, 32'h0, 32'h100, 32'hF7);
      bus(32'h2002, 32'hDFFF1234, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0);
      // patch the lower half-word at 2000, then put it back
      r = 32'h1234ABCD;
      saved = r;
      r[15:0] = 16'hDFFF;
      bus(32'h2000, r, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0);
      bus(32'h2002, r, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0);
      r = saved;
      bus(32'h2000, r, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0);
      $display("test software breakpoint done");
      u_host.prog(2'h0, 32'h400, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h10D, 32'hF0);
      bus(32'h400, 32'h5, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
      bus(32'h400, 32'h5, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
      bus(32'h400, 32'h5, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
      $display("test watchpoint done");
      mon <= 1'b1;
      bus(32'h400, 32'h5, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
      abort_in(1'b1);
      chk("flag", 32'h00000000, {31'h0, flag});
      bus(32'h400, 32'h5, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
      abort_in(1'b0);
      chk("flag", 32'h00000001, {31'h0, flag});
      repeat (3) @(posedge clk);
      #1;
      chk("flag", 32'h00000001, {31'h0, flag});
      cp(1'b0, 1'b0);
      chk("cause", 32'h00000001, cprd);
      cp(1'b1, 1'b0);
      chk("flag", 32'h00000000, {31'h0, flag});
      cp(1'b0, 1'b0);
      chk("cause", 32'h00000000, cprd);
      $display("test abort flag done");
      end_of_test();
   end
endmodule : wbm_match_bench

`default_nettype wire
